// *** common/rcr_pkg.sv ***
// Purpose: constants of the reset cause recorder
// Assumes: 32-bit register port, byte addresses
// Notes:   definitions only
package rcr_pkg;
    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] RCR_OFS_CAUSE  = 8'h00;
    localparam logic [7:0] RCR_OFS_STATUS = 8'h04;
    localparam logic [7:0] RCR_OFS_MASK   = 8'h08;
    // -----------------------------------------------------------------
    // reset cause record fields
    // -----------------------------------------------------------------
    localparam int RCR_BIT_POR  = 0;
    localparam int RCR_BIT_CORE = 1;
    localparam int RCR_BIT_IO   = 2;
    localparam int RCR_BIT_PIN  = 4;
    localparam int RCR_BIT_WDOG = 5;
    localparam int RCR_BIT_SYS  = 6;
    localparam logic [7:0] RCR_CAUSE_USED = 8'h77;
    localparam logic [7:0] RCR_RESET_POR  = 8'h01;
    // -----------------------------------------------------------------
    // interrupt status fields
    // -----------------------------------------------------------------
    localparam int RCR_EV_CAPTURE = 0;
    localparam int RCR_EV_WR_RO   = 1;
    localparam int RCR_EV_BAD     = 2;
    localparam int RCR_EV_W       = 3;
    localparam logic [2:0] RCR_RESET_EV = 3'h0;
    // -----------------------------------------------------------------
    // legal byte enables: byte, halfword, word
    // -----------------------------------------------------------------
    localparam logic [3:0] RCR_BE_B0 = 4'h1;
    localparam logic [3:0] RCR_BE_B1 = 4'h2;
    localparam logic [3:0] RCR_BE_B2 = 4'h4;
    localparam logic [3:0] RCR_BE_B3 = 4'h8;
    localparam logic [3:0] RCR_BE_H0 = 4'h3;
    localparam logic [3:0] RCR_BE_H1 = 4'hC;
    localparam logic [3:0] RCR_BE_W  = 4'hF;
    typedef enum {
        RCR_ACC_IDLE,
        RCR_ACC_READ,
        RCR_ACC_WRITE
    } rcr_acc_t;
endpackage

// *** hdl/rcr_recorder.sv ***
// Purpose: record the source of the latest device reset
// Assumes: i_resetn is the power-on reset; other sources are
//          synchronous levels held high while their reset lasts
// Notes:   this block stays alive through the resets it reports
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps

module rcr_recorder
    import rcr_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_sys_request,
    input  wire logic        i_watchdog_expired,
    input  wire logic        i_external_pin,
    input  wire logic        i_io_supply_brownout,
    input  wire logic        i_core_supply_brownout,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_be,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic      [7:0]  o_reset_cause_record,
    output logic             o_irq
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0]          cause_q;
    logic [7:0]          cause_d;
    logic                src_any;
    logic                src_any_q;
    logic [RCR_EV_W-1:0] status_q;
    logic [RCR_EV_W-1:0] mask_q;
    logic [RCR_EV_W-1:0] event_set;
    logic [31:0]         rdata_q;
    logic [31:0]         rd_word;
    logic                be_ok;
    logic                hit_cause;
    logic                hit_status;
    logic                hit_mask;
    logic                mapped;
    rcr_acc_t            acc;

    // -----------------------------------------------------------------
    // reset source selection
    // -----------------------------------------------------------------

    // any reported reset source active
    assign src_any = i_sys_request | i_watchdog_expired
                   | i_external_pin | i_io_supply_brownout
                   | i_core_supply_brownout;

    // one-hot flag for the strongest active source
    always_comb begin
        cause_d = 8'h00;
        if (i_core_supply_brownout) begin
            cause_d[RCR_BIT_CORE] = 1'b1;
        end else if (i_io_supply_brownout) begin
            cause_d[RCR_BIT_IO] = 1'b1;
        end else if (i_external_pin) begin
            cause_d[RCR_BIT_PIN] = 1'b1;
        end else if (i_watchdog_expired) begin
            cause_d[RCR_BIT_WDOG] = 1'b1;
        end else if (i_sys_request) begin
            cause_d[RCR_BIT_SYS] = 1'b1;
        end
    end

    // record: power-on loads its flag, later sources overwrite it
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cause_q <= RCR_RESET_POR;
        end else if (src_any) begin
            cause_q <= cause_d;
        end
    end

    // previous source level, for the capture event
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_any_q <= 1'b0;
        end else begin
            src_any_q <= src_any;
        end
    end

    assign o_reset_cause_record = cause_q;

    // -----------------------------------------------------------------
    // register port decode
    // -----------------------------------------------------------------

    // access kind of this cycle
    always_comb begin
        if (i_rd) begin
            acc = RCR_ACC_READ;
        end else if (i_wr) begin
            acc = RCR_ACC_WRITE;
        end else begin
            acc = RCR_ACC_IDLE;
        end
    end

    // byte, halfword or word enables only
    always_comb begin
        case (i_be)
            RCR_BE_B0, RCR_BE_B1,
            RCR_BE_B2, RCR_BE_B3,
            RCR_BE_H0, RCR_BE_H1,
            RCR_BE_W: be_ok = 1'b1;
            default: be_ok = 1'b0;
        endcase
    end

    // word decode, low address bits select lanes through i_be
    assign hit_cause  = (i_addr[7:2] == RCR_OFS_CAUSE[7:2]);
    assign hit_status = (i_addr[7:2] == RCR_OFS_STATUS[7:2]);
    assign hit_mask   = (i_addr[7:2] == RCR_OFS_MASK[7:2]);
    assign mapped     = hit_cause | hit_status | hit_mask;

    // word seen by a read before lane masking
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_cause) begin
            rd_word[7:0] = cause_q & RCR_CAUSE_USED;
        end else if (hit_status) begin
            rd_word[RCR_EV_W-1:0] = status_q;
        end else if (hit_mask) begin
            rd_word[RCR_EV_W-1:0] = mask_q;
        end
    end

    // read data for one cycle only, unselected lanes zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc == RCR_ACC_READ && be_ok) begin
            rdata_q <= rd_word & {{8{i_be[3]}}, {8{i_be[2]}},
                                  {8{i_be[1]}}, {8{i_be[0]}}};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_q;

    // -----------------------------------------------------------------
    // interrupt events
    // -----------------------------------------------------------------

    // events raised this cycle
    always_comb begin
        event_set = '0;
        event_set[RCR_EV_CAPTURE] = src_any & ~src_any_q;
        event_set[RCR_EV_WR_RO]   = (acc == RCR_ACC_WRITE)
                                  & hit_cause & be_ok;
        event_set[RCR_EV_BAD]     = (acc != RCR_ACC_IDLE)
                                  & (~mapped | ~be_ok);
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= RCR_RESET_EV;
        end else if (acc == RCR_ACC_WRITE && hit_status && be_ok
                     && i_be[0]) begin
            status_q <= (status_q & ~i_wdata[RCR_EV_W-1:0])
                      | event_set;
        end else begin
            status_q <= status_q | event_set;
        end
    end

    // mask register, lane 0 only carries bits
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask_q <= RCR_RESET_EV;
        end else if (acc == RCR_ACC_WRITE && hit_mask && be_ok
                     && i_be[0]) begin
            mask_q <= i_wdata[RCR_EV_W-1:0];
        end
    end

    // level interrupt while an unmasked flag stands
    assign o_irq = |(status_q & mask_q);

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------

    // set by power-on, cleared once another source is seen
    logic por_only_q;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            por_only_q <= 1'b1;
        end else if (src_any) begin
            por_only_q <= 1'b0;
        end
    end

    sequence s_read_cause;
        i_rd && hit_cause && i_be == RCR_BE_W;
    endsequence

    sequence s_write_cause;
        i_wr && hit_cause && !src_any;
    endsequence

    sequence s_bad_access;
        (i_rd || i_wr) && !be_ok;
    endsequence

    // a write with legal lanes aimed at the record
    sequence s_write_flag;
        i_wr && hit_cause && be_ok;
    endsequence

    // first edge of a reported reset source
    sequence s_capture;
        src_any && !src_any_q;
    endsequence

    // a write that must be dropped: bad lanes or no register
    sequence s_bad_write;
        i_wr && !i_rd && (!be_ok || !mapped);
    endsequence

    a_cause_onehot: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        $onehot(cause_q) && (cause_q & ~RCR_CAUSE_USED) == 8'h00)
        else $error("cause record not one-hot");

    a_sys_capture: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_sys_request && !i_watchdog_expired && !i_external_pin
        && !i_io_supply_brownout && !i_core_supply_brownout
        |=> cause_q == (8'h01 << RCR_BIT_SYS))
        else $error("system request not recorded");

    // watchdog beats a request, loses to pin and supplies
    a_wdog_capture: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_watchdog_expired && !i_external_pin
        && !i_io_supply_brownout && !i_core_supply_brownout
        |=> cause_q[RCR_BIT_WDOG] && !cause_q[RCR_BIT_SYS])
        else $error("watchdog not recorded");

    // pin flag set, then kept until another source shows
    a_pin_capture: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_external_pin && !i_io_supply_brownout
        && !i_core_supply_brownout
        |=> cause_q[RCR_BIT_PIN] ##1 (src_any_q || cause_q[RCR_BIT_PIN]))
        else $error("external pin not recorded");

    a_io_capture: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_io_supply_brownout && !i_core_supply_brownout
        |=> cause_q[RCR_BIT_IO])
        else $error("io brown-out not recorded");

    a_core_capture: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_core_supply_brownout |=> cause_q[RCR_BIT_CORE])
        else $error("core brown-out not recorded");

    a_por_hold: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        por_only_q |-> cause_q == RCR_RESET_POR)
        else $error("power-on flag lost");

    // -----------------------------------------------------------------
    // checks of the register port and the interrupt
    // -----------------------------------------------------------------

    // a word read returns the record in lane 0
    a_cause_read: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_read_cause |=> o_rdata == {24'h000000, $past(cause_q)}
        && o_rdata[7] == 1'b0 && o_rdata[3] == 1'b0)
        else $error("cause read wrong");

    // illegal lanes read zero and raise the bad flag
    a_bad_flag: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_bad_access |=> status_q[RCR_EV_BAD] && o_rdata == 32'h0)
        else $error("illegal lanes not flagged");

    // a lane without the record reads zero
    a_lane_read: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_rd && hit_cause && i_be == RCR_BE_B1 |=> o_rdata == 32'h0)
        else $error("unselected lane not zero");

    // software cannot move the record
    a_write_ignored: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_write_cause |=> $stable(cause_q))
        else $error("write altered cause record");

    // a dropped write to the record is reported
    a_write_flag: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_write_flag |=> status_q[RCR_EV_WR_RO])
        else $error("record write not flagged");

    // no source, no change: the record outlives the reset
    a_hold_idle: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        !src_any |=> $stable(cause_q))
        else $error("record changed with no source");

    // read data stand only in the cycle after a read
    a_rdata_idle: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    // words outside the map read as zero
    a_unmapped_read: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i_rd && !mapped |=> o_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // a refused write leaves the mask and raises the bad flag
    a_bad_write: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_bad_write |=> $stable(mask_q) && status_q[RCR_EV_BAD])
        else $error("refused write took effect");

    // a capture is flagged and, when unmasked, interrupts
    a_irq_level: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        s_capture |=> status_q[RCR_EV_CAPTURE]
        && (o_irq || !mask_q[RCR_EV_CAPTURE]))
        else $error("capture not flagged or interrupt missing");
endmodule

// *** testbench/rcr_src_model.sv ***
// Purpose: on-chip reset sources seen by the recorder
// Assumes: a request holds its pattern for four clock cycles
// Notes:   sources are active-high levels, low when idle
`timescale 1ns/10ps
module rcr_src_model (
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_go,
    input  wire logic [4:0] i_pat,
    output logic      [4:0] o_src
);
    logic [1:0] left_q;
    // -----------------------------------------------------------------
    // hold the requested pattern, then drop every source low
    // -----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            left_q <= 2'h0;
            o_src  <= 5'h00;
        end else if (i_go) begin
            left_q <= 2'h3;
            o_src  <= i_pat;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
        end else begin
            o_src <= 5'h00;
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench of the reset cause recorder
// Assumes: sources are driven by the source model
// Notes:   random patterns from a fixed xorshift seed
`timescale 1ns/10ps
module tb_top;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'h0;
    logic [4:0]  pat = 5'h00;
    logic [4:0]  src;
    logic [31:0] rdata;
    logic [7:0]  rec;
    logic        irq;
    logic [31:0] d;
    logic [31:0] seed = 32'h5F8186F5;
    logic [7:0]  exp_rec;
    logic [3:0]  bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
    int          errors = 0;
    int          checked = 0;
    // clock of 40 ns
    always #20 mclk = ~mclk;
    rcr_src_model u_src (.i_mclk(mclk), .i_resetn(resetn), .i_go(go),
        .i_pat(pat), .o_src(src));
    rcr_recorder dut (.i_mclk(mclk), .i_resetn(resetn),
        .i_sys_request(src[0]), .i_watchdog_expired(src[1]),
        .i_external_pin(src[2]), .i_io_supply_brownout(src[3]),
        .i_core_supply_brownout(src[4]), .i_addr(addr), .i_wdata(wdata),
        .i_be(be), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_reset_cause_record(rec), .o_irq(irq));
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // strongest source wins: core, io, pin, watchdog, request
    function automatic logic [7:0] want(input logic [4:0] p);
        if (p[4]) return 8'h02;
        if (p[3]) return 8'h04;
        if (p[2]) return 8'h10;
        if (p[1]) return 8'h20;
        return 8'h40;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrt(input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        be <= b;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rdd(input logic [7:0] a, input logic [3:0] b);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        be <= b;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic fire(input logic [4:0] p);
        @(posedge mclk);
        go <= 1'b1;
        pat <= p;
        @(posedge mclk);
        go <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 exp_rec = want(p);
        chk("record", {24'h0, rec}, {24'h0, exp_rec});
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("record", {24'h0, rec}, 32'h1);
        rdd(8'h00, 4'hF);
        chk("read record", d, 32'h1);
        // each source alone
        for (int i = 0; i < 5; i++) begin
            fire(5'h01 << i);
            rdd(8'h00, 4'h1);
            chk("read record", d, {24'h0, exp_rec});
        end
        // random overlapping sources
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            fire((seed[4:0] == 5'h00) ? 5'h01 : seed[4:0]);
        end
        // every legal access size
        foreach (bes[i]) begin
            rdd(8'h00, bes[i]);
            chk("lane read", d, bes[i][0] ? {24'h0, exp_rec} : 32'h0);
        end
        // writes to the record are dropped
        wrt(8'h04, 4'h1, 32'h7);
        wrt(8'h00, 4'hF, 32'hFFFFFFFF);
        rdd(8'h00, 4'hF);
        chk("record after write", d, {24'h0, exp_rec});
        rdd(8'h04, 4'h1);
        chk("status write flag", d, 32'h2);
        rdd(8'h00, 4'h5);
        chk("illegal lanes", d, 32'h0);
        rdd(8'h0C, 4'hF);
        chk("unmapped", d, 32'h0);
        rdd(8'h04, 4'h1);
        chk("status bad flag", d, 32'h6);
        // illegal lanes on the record count as bad, not as a write
        wrt(8'h04, 4'h1, 32'h7);
        wrt(8'h00, 4'h5, 32'hFF);
        rdd(8'h04, 4'h1);
        chk("bad write flag", d, 32'h4);
        chk("record after bad write", {24'h0, rec}, {24'h0, exp_rec});
        // a write to no register is dropped and flagged
        wrt(8'h04, 4'h1, 32'h7);
        wrt(8'h0C, 4'hF, 32'hFF);
        rdd(8'h04, 4'h1);
        chk("unmapped write flag", d, 32'h4);
        // interrupt raise, clear and mask
        wrt(8'h04, 4'h1, 32'h7);
        wrt(8'h08, 4'h1, 32'h1);
        chk("irq idle", {31'h0, irq}, 32'h0);
        fire(5'h02);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wrt(8'h04, 4'h1, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wrt(8'h08, 4'h1, 32'h0);
        fire(5'h01);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdd(8'h04, 4'h1);
        chk("status capture", d, 32'h1);
        // second power-on in mid-run
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("record", {24'h0, rec}, 32'h1);
        rdd(8'h04, 4'hF);
        chk("status after reset", d, 32'h0);
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
endmodule
